// ---- dsss_pkg.sv ----
// constants, types and register map of the drive start/stop sequencer
// Behaviour
// [R1] start mode 0 starts at start frequency, 1 starts by speed tracing
// [R2] plain start begins output at the start frequency, not at zero
// [R3] tracing start finds motor speed and direction, then outputs matching frequency
// [R4] tracing sweeps the trial frequency downward from high to low
// [R5] current above tracing over-current level pauses the sweep
// [R6] stop mode 0 ramps down, 1 coasts
// [R7] ramped stop lowers frequency at the deceleration time rate
// [R8] at stop frequency apply DC braking if configured, else coast
// [R9] coasting stop cuts frequency output at once
// [R10] start frequency 0.10 to 10.00 in 0.01 steps, default 0.5
// [R11] stop frequency 0.10 to 10.00 Hz, default 0.5 Hz, ramp end point
// [R12] pre-start DC braking current percent of rated, 0 to 150, default 100
// [R13] pre-start braking time 0 to 250, default 0, zero disables it
// [R14] post-stop DC braking current percent of rated, 0 to 150, default 100
// [R15] post-stop braking time 0 to 250, default 0, zero disables it
// [R16] torque boost raises voltage, 0.1 to 20 percent, default 5 percent
// [R17] running current above rated motor current trips and stops driving
// [R18] slip compensation from rated slip 0 to 100, default 2.5
// [R19] speed display scaled from rated speed at 50 Hz, 0 to 6000, default 1420
// [R20] after pre-start braking go straight into the selected start mode
`default_nettype none
package dsss_pkg;
  localparam int          CLK_NS         = 4;
  localparam int          RAMP_TICK_NS   = 20000;
  localparam int          RAMP_TICK_CYC  = (RAMP_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          BRAKE_TICK_MS  = 100;
  localparam int          BRAKE_TICK_CYC = BRAKE_TICK_MS * 1000000 / CLK_NS;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_TARGET     = 8'h04;
  localparam logic [7:0]  OFS_START      = 8'h08;
  localparam logic [7:0]  OFS_STOP       = 8'h0c;
  localparam logic [7:0]  OFS_PRE        = 8'h10;
  localparam logic [7:0]  OFS_POST       = 8'h14;
  localparam logic [7:0]  OFS_BOOST      = 8'h18;
  localparam logic [7:0]  OFS_RCUR       = 8'h1c;
  localparam logic [7:0]  OFS_RSPD       = 8'h20;
  localparam logic [7:0]  OFS_SLIP       = 8'h24;
  localparam logic [7:0]  OFS_RAMP       = 8'h28;
  localparam logic [7:0]  OFS_TROC       = 8'h2c;
  localparam logic [7:0]  OFS_STATUS     = 8'h30;
  localparam logic [7:0]  OFS_SPEED      = 8'h34;
  localparam int          CTRL_START_B   = 0;
  localparam int          CTRL_STOP_B    = 1;
  localparam int          CTRL_RUN_B     = 2;
  localparam int          CTRL_REV_B     = 3;
  localparam int          CTRL_TCLR_B    = 4;
  localparam logic [15:0] FREQ_MIN       = 16'h000a;
  localparam logic [15:0] FREQ_MAX_SET   = 16'h03e8;
  localparam logic [15:0] FREQ_DEF       = 16'h0032;
  localparam logic [15:0] TOP_FREQ       = 16'h1388;
  localparam logic [7:0]  BRK_LVL_MAX    = 8'h96;
  localparam logic [7:0]  BRK_LVL_DEF    = 8'h64;
  localparam logic [7:0]  BRK_DUR_MAX    = 8'hfa;
  localparam logic [7:0]  BRK_DUR_DEF    = 8'h00;
  localparam logic [7:0]  BOOST_MIN      = 8'h01;
  localparam logic [7:0]  BOOST_MAX      = 8'hc8;
  localparam logic [7:0]  BOOST_DEF      = 8'h32;
  localparam logic [15:0] RCUR_DEF       = 16'h0064;
  localparam logic [12:0] RSPD_MAX       = 13'h1770;
  localparam logic [12:0] RSPD_DEF       = 13'h058c;
  localparam logic [9:0]  SLIP_MAX       = 10'h3e8;
  localparam logic [9:0]  SLIP_DEF       = 10'h019;
  localparam logic [15:0] RAMP_DEF       = 16'h0032;
  localparam logic [15:0] TROC_DEF       = 16'h0096;
  localparam logic [15:0] TARGET_DEF     = 16'h1388;
  localparam logic [10:0] VOLT_MAX       = 11'h3e8;
  localparam logic [13:0] VOLT_RECIP     = 14'h3333;
  localparam logic [13:0] SPEED_RECIP    = 14'h346e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PREBRAKE, ST_TRACE, ST_RUN, ST_DECEL, ST_POSTBRAKE, ST_TRIP
  } dsss_state_e;
endpackage
`default_nettype wire

// ---- dsss_top.sv ----
// drive start/stop sequencer with apb register file
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dsss_top #(
  parameter int RAMP_TICK = dsss_pkg::RAMP_TICK_CYC,
  parameter int BRAKE_TICK = dsss_pkg::BRAKE_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] motor_current,
  input  wire logic        trace_match,
  input  wire logic        motor_reverse,
  output logic [15:0]      out_freq,
  output logic             out_reverse,
  output logic [10:0]      out_volt,
  output logic             gate_en,
  output logic             dc_brake,
  output logic [7:0]       brake_level,
  output logic [15:0]      speed_rpm,
  output logic             trip
);
  import dsss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // setting clamps: out-of-range writes are pulled to the nearest legal value
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0]  ctrl_q;
  logic [15:0] target_q;
  logic [15:0] start_freq_setting_q;
  logic [15:0] stop_freq_setting_q;
  logic [7:0]  prestart_brake_level_q;
  logic [7:0]  prestart_brake_duration_q;
  logic [7:0]  poststop_brake_level_q;
  logic [7:0]  poststop_brake_duration_q;
  logic [7:0]  voltage_boost_percent_q;
  logic [15:0] motor_rated_current_q;
  logic [12:0] motor_rated_speed_q;
  logic [9:0]  motor_rated_slip_q;
  logic [15:0] accel_time_q;
  logic [15:0] decel_time_q;
  logic [15:0] trace_oc_level_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        trip_clr_q;
  ////////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state so read data comes from a flop
  wire         acc_en = psel & penable & pready_q;
  wire         wr_en  = acc_en & pwrite;
  wire         mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_SPEED);
  wire [15:0]  wlo    = pwdata[15:0];
  wire [7:0]   wb0    = pwdata[7:0];
  wire [7:0]   wb1    = pwdata[15:8];
  wire [15:0]  rspd_lim = clamp16(wlo, 16'h0000, {3'h0, RSPD_MAX});
  wire [15:0]  slip_lim = clamp16(wlo, 16'h0000, {6'h00, SLIP_MAX});
  dsss_state_e state_q;
  dsss_state_e state_d;
  logic [15:0] freq_q;
  logic [15:0] freq_d;
  logic        dir_q;
  logic        dir_d;
  logic [15:0] speed_q;
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:   rd_mux = {28'h000_0000, ctrl_q[3:0]};
      OFS_TARGET: rd_mux = {16'h0000, target_q};
      OFS_START:  rd_mux = {16'h0000, start_freq_setting_q};
      OFS_STOP:   rd_mux = {16'h0000, stop_freq_setting_q};
      OFS_PRE:    rd_mux = {16'h0000, prestart_brake_duration_q, prestart_brake_level_q};
      OFS_POST:   rd_mux = {16'h0000, poststop_brake_duration_q, poststop_brake_level_q};
      OFS_BOOST:  rd_mux = {24'h00_0000, voltage_boost_percent_q};
      OFS_RCUR:   rd_mux = {16'h0000, motor_rated_current_q};
      OFS_RSPD:   rd_mux = {19'h0_0000, motor_rated_speed_q};
      OFS_SLIP:   rd_mux = {22'h00_0000, motor_rated_slip_q};
      OFS_RAMP:   rd_mux = {decel_time_q, accel_time_q};
      OFS_TROC:   rd_mux = {16'h0000, trace_oc_level_q};
      OFS_STATUS: rd_mux = {freq_q, 11'h000, dir_q, (state_q == ST_TRIP), state_q};
      OFS_SPEED:  rd_mux = {16'h0000, speed_q};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite & mapped) ? rd_mux : 32'h0000_0000;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q                    <= 5'h00;
      target_q                  <= TARGET_DEF;
      start_freq_setting_q      <= FREQ_DEF;
      stop_freq_setting_q       <= FREQ_DEF;
      prestart_brake_level_q    <= BRK_LVL_DEF;
      prestart_brake_duration_q <= BRK_DUR_DEF;
      poststop_brake_level_q    <= BRK_LVL_DEF;
      poststop_brake_duration_q <= BRK_DUR_DEF;
      voltage_boost_percent_q   <= BOOST_DEF;
      motor_rated_current_q     <= RCUR_DEF;
      motor_rated_speed_q       <= RSPD_DEF;
      motor_rated_slip_q        <= SLIP_DEF;
      accel_time_q              <= RAMP_DEF;
      decel_time_q              <= RAMP_DEF;
      trace_oc_level_q          <= TROC_DEF;
      trip_clr_q                <= 1'b0;
    end
    else
    begin
      trip_clr_q <= wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_TCLR_B];
      if (wr_en)
      begin
        unique case (paddr)
          OFS_CTRL:   ctrl_q <= {1'b0, pwdata[3:0]}; // R1 R6
          OFS_TARGET: target_q <= clamp16(wlo, 16'h0000, TOP_FREQ);
          OFS_START:  start_freq_setting_q <= clamp16(wlo, FREQ_MIN, FREQ_MAX_SET); // R10
          OFS_STOP:   stop_freq_setting_q <= clamp16(wlo, FREQ_MIN, FREQ_MAX_SET); // R11
          OFS_PRE:
          begin
            prestart_brake_level_q    <= clamp8(wb0, 8'h00, BRK_LVL_MAX); // R12
            prestart_brake_duration_q <= clamp8(wb1, 8'h00, BRK_DUR_MAX); // R13
          end
          OFS_POST:
          begin
            poststop_brake_level_q    <= clamp8(wb0, 8'h00, BRK_LVL_MAX); // R14
            poststop_brake_duration_q <= clamp8(wb1, 8'h00, BRK_DUR_MAX); // R15
          end
          OFS_BOOST:  voltage_boost_percent_q <= clamp8(wb0, BOOST_MIN, BOOST_MAX); // R16
          OFS_RCUR:   motor_rated_current_q <= wlo;
          OFS_RSPD:   motor_rated_speed_q <= rspd_lim[12:0]; // R19
          OFS_SLIP:   motor_rated_slip_q <= slip_lim[9:0]; // R18
          OFS_RAMP:
          begin
            accel_time_q <= wlo;
            decel_time_q <= pwdata[31:16];
          end
          OFS_TROC:   trace_oc_level_q <= wlo;
          default:    ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timebases: ramp step tick and braking duration tick
  logic [31:0] ramp_pre_q;
  logic [31:0] brake_pre_q;
  logic [15:0] step_cnt_q;
  logic [7:0]  brake_cnt_q;
  wire         ramp_tick  = (ramp_pre_q == 32'(RAMP_TICK - 1));
  wire         brake_tick = (brake_pre_q == 32'(BRAKE_TICK - 1));
  wire         run_cmd    = ctrl_q[CTRL_RUN_B];
  wire         start_mode_select = ctrl_q[CTRL_START_B];
  wire         stop_mode_select  = ctrl_q[CTRL_STOP_B];
  // step interval in ticks follows the accel or decel setting; tracing sweeps every tick
  wire [15:0]  step_time  = (state_q == ST_DECEL) ? decel_time_q :
                            ((state_q == ST_TRACE) ? 16'h0001 : accel_time_q);
  wire [16:0]  step_next  = {1'b0, step_cnt_q} + 17'h00001;
  wire         step_now   = ramp_tick && (step_next >= {1'b0, step_time}); // R7
  wire [7:0]   brake_dur  = (state_q == ST_POSTBRAKE) ? poststop_brake_duration_q :
                                                         prestart_brake_duration_q;
  wire         brake_done = (brake_cnt_q >= brake_dur);
  wire         trace_hold = (motor_current > trace_oc_level_q); // R5
  wire         over_cur   = (motor_current > motor_rated_current_q);
  wire         energised  = (state_q != ST_IDLE) && (state_q != ST_TRIP);
  wire [15:0]  run_target = (target_q < start_freq_setting_q) ? start_freq_setting_q : target_q;
  wire         chg        = (state_d != state_q);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_pre_q  <= 32'h0000_0000;
      brake_pre_q <= 32'h0000_0000;
      step_cnt_q  <= 16'h0000;
      brake_cnt_q <= 8'h00;
    end
    else
    begin
      ramp_pre_q  <= ramp_tick ? 32'h0000_0000 : ramp_pre_q + 32'h0000_0001;
      brake_pre_q <= (brake_tick || chg) ? 32'h0000_0000 : brake_pre_q + 32'h0000_0001;
      step_cnt_q  <= (chg || step_now) ? 16'h0000 : (ramp_tick ? step_next[15:0] : step_cnt_q);
      brake_cnt_q <= chg ? 8'h00 : ((brake_tick && !brake_done) ? brake_cnt_q + 8'h01
                                                                   : brake_cnt_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb
  begin
    state_d = state_q;
    freq_d  = freq_q;
    dir_d   = dir_q;
    unique case (state_q)
      ST_IDLE:
      begin
        freq_d = 16'h0000;
        if (run_cmd)
        begin
          dir_d = ctrl_q[CTRL_REV_B];
          if (prestart_brake_duration_q != 8'h00)
            state_d = ST_PREBRAKE; // R12 R13
          else if (start_mode_select)
          begin
            state_d = ST_TRACE; // R1 R3
            freq_d  = TOP_FREQ; // R4
          end
          else
          begin
            state_d = ST_RUN; // R1
            freq_d  = start_freq_setting_q; // R2
          end
        end
      end
      ST_PREBRAKE:
      begin
        if (!run_cmd)
          state_d = ST_IDLE;
        else if (brake_done && start_mode_select)
        begin
          state_d = ST_TRACE; // R20
          freq_d  = TOP_FREQ; // R4
        end
        else if (brake_done)
        begin
          state_d = ST_RUN; // R20
          freq_d  = start_freq_setting_q; // R2
        end
      end
      ST_TRACE:
      begin
        if (!run_cmd)
          state_d = ST_IDLE;
        else if (trace_match)
        begin
          state_d = ST_RUN; // R3
          dir_d   = motor_reverse; // R3
        end
        else if (step_now && !trace_hold) // R5
        begin
          if (freq_q <= start_freq_setting_q)
          begin
            state_d = ST_RUN;
            freq_d  = start_freq_setting_q;
          end
          else
            freq_d = freq_q - 16'h0001; // R4
        end
      end
      ST_RUN:
      begin
        if (!run_cmd)
          state_d = stop_mode_select ? ST_IDLE : ST_DECEL; // R6 R9
        else if (step_now && (freq_q < run_target))
          freq_d = freq_q + 16'h0001;
        else if (step_now && (freq_q > run_target))
          freq_d = freq_q - 16'h0001;
      end
      ST_DECEL:
      begin
        if (run_cmd)
          state_d = ST_RUN;
        else if (freq_q <= stop_freq_setting_q) // R11
          state_d = (poststop_brake_duration_q != 8'h00) ? ST_POSTBRAKE : ST_IDLE; // R8 R15
        else if (step_now)
          freq_d = freq_q - 16'h0001; // R7
      end
      ST_POSTBRAKE:
        if (brake_done)
          state_d = ST_IDLE; // R15
      ST_TRIP:
      begin
        freq_d = 16'h0000;
        if (trip_clr_q && !run_cmd)
          state_d = ST_IDLE;
      end
      default: state_d = ST_TRIP;
    endcase
    // trip outranks every other transition of an energised state; in ST_TRIP a trip clear wins over an over-current
    if (energised && over_cur)
    begin
      state_d = ST_TRIP; // R17
      freq_d  = 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // output shaping: slip compensation, boost, speed display
  wire [25:0]  slip_prod  = freq_q * motor_rated_slip_q;
  // divide by 1024 instead of 1000: about 2 percent low, saves a divider
  wire [16:0]  freq_comp  = {1'b0, freq_q} + {1'b0, slip_prod[25:10]}; // R18
  wire [15:0]  freq_sat   = freq_comp[16] ? 16'hffff : freq_comp[15:0];
  wire         driving    = (state_q == ST_TRACE) || (state_q == ST_RUN) ||
                            (state_q == ST_DECEL);
  wire         braking    = (state_q == ST_PREBRAKE) || (state_q == ST_POSTBRAKE);
  wire [29:0]  volt_prod  = freq_q * VOLT_RECIP;
  wire [14:0]  volt_sum   = {1'b0, volt_prod[29:16]} + {7'h00, voltage_boost_percent_q}; // R16
  wire [10:0]  volt_sat   = (volt_sum > {4'h0, VOLT_MAX}) ? VOLT_MAX : volt_sum[10:0];
  wire [28:0]  rpm_prod   = out_freq * motor_rated_speed_q;
  wire [42:0]  rpm_scaled = rpm_prod * SPEED_RECIP;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= ST_IDLE;
      freq_q      <= 16'h0000;
      dir_q       <= 1'b0;
      speed_q     <= 16'h0000;
      out_freq    <= 16'h0000;
      out_reverse <= 1'b0;
      out_volt    <= 11'h000;
      gate_en     <= 1'b0;
      dc_brake    <= 1'b0;
      brake_level <= 8'h00;
      trip        <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      freq_q      <= freq_d;
      dir_q       <= dir_d;
      speed_q     <= rpm_scaled[41:26]; // R19
      out_freq    <= driving ? (state_q == ST_TRACE ? freq_q : freq_sat) : 16'h0000; // R9
      out_reverse <= dir_q;
      out_volt    <= driving ? volt_sat : 11'h000;
      gate_en     <= driving || braking; // R8 R17
      dc_brake    <= braking; // R8
      brake_level <= (state_q == ST_POSTBRAKE) ? poststop_brake_level_q : // R14
                     (braking ? prestart_brake_level_q : 8'h00); // R12
      trip        <= (state_q == ST_TRIP); // R17
    end
  end
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign speed_rpm = speed_q;
endmodule
`default_nettype wire

// ---- dsss_checker.sv ----
// assertion checker for the drive start/stop sequencer ports
`timescale 1ns/10ps
`default_nettype none
module dsss_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] out_freq,
  input wire logic [10:0] out_volt,
  input wire logic        gate_en,
  input wire logic        dc_brake,
  input wire logic [7:0]  brake_level,
  input wire logic        trip
);
  import dsss_pkg::*;
  wire ctrl_wr = psel && penable && pwrite && (paddr == OFS_CTRL);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_waiting;
    psel && penable && !pready;
  endsequence
  // a clear needs a few cycles to reach the trip output
  sequence s_quiet_trip;
    (!ctrl_wr) [*4] ##0 trip;
  endsequence
  ready_next_a: assert property (s_waiting |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  trip_off_a: assert property (trip |-> !gate_en && !dc_brake)
    else $error("drive active in trip");
  trip_hold_a: assert property (s_quiet_trip |=> trip) else $error("trip lost");
  brake_zero_a: assert property (!dc_brake |-> brake_level == 8'h00)
    else $error("brake level without braking");
  brake_max_a: assert property (brake_level <= BRK_LVL_MAX)
    else $error("brake level above limit");
  coast_zero_a: assert property (!gate_en |-> out_freq == 16'h0 && out_volt == 11'h0)
    else $error("output while coasting");
  volt_max_a: assert property (out_volt <= VOLT_MAX) else $error("voltage above clamp");
  brake_gate_a: assert property (dc_brake |-> gate_en)
    else $error("braking with gates off");
endmodule
bind dsss_top dsss_checker dsss_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .out_freq(out_freq), .out_volt(out_volt), .gate_en(gate_en),
  .dc_brake(dc_brake), .brake_level(brake_level), .trip(trip));
`default_nettype wire

// ---- dsss_motor_model.sv ----
// induction motor stand-in: load current, speed detector and direction
`timescale 1ns/10ps
`default_nettype none
module dsss_motor_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] out_freq,
  input  wire logic        gate_en,
  input  wire logic        dc_brake,
  input  wire logic [15:0] load_cur,
  input  wire logic [15:0] spin_freq,
  input  wire logic        spin_rev,
  output logic [15:0]      motor_current,
  output logic             trace_match,
  output logic             motor_reverse
);
  // an unpowered motor draws nothing, so current follows gate_en
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      motor_current <= 16'h0;
      trace_match <= 1'b0;
      motor_reverse <= 1'b0;
    end
    else
    begin
      motor_current <= gate_en ? load_cur : 16'h0;
      trace_match <= gate_en && !dc_brake && (out_freq <= spin_freq);
      motor_reverse <= spin_rev;
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the drive start/stop sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
  end
module testbench;
  import dsss_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'haf05;
  logic        pready, pslverr, trace_match, motor_reverse, out_reverse, gate_en;
  logic        dc_brake, trip, spin_rev = 1'b0;
  logic [15:0] motor_current, out_freq, speed_rpm, v, prev;
  logic [15:0] load_cur = 16'h0, spin_freq = 16'h0;
  logic [10:0] out_volt;
  logic [7:0]  brake_level;
  logic [32:0] exp_q[$], got, want;
  int          n_mismatch = 0, cmp_count = 0, n;
  always #2 pclk = ~pclk;
  dsss_top #(.RAMP_TICK(4), .BRAKE_TICK(8)) dsss_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_current(motor_current),
    .trace_match(trace_match), .motor_reverse(motor_reverse), .out_freq(out_freq),
    .out_reverse(out_reverse), .out_volt(out_volt), .gate_en(gate_en), .dc_brake(dc_brake),
    .brake_level(brake_level), .speed_rpm(speed_rpm), .trip(trip));
  dsss_motor_model dsss_motor_model_inst (.pclk(pclk), .presetn(presetn), .out_freq(out_freq),
    .gate_en(gate_en), .dc_brake(dc_brake), .load_cur(load_cur), .spin_freq(spin_freq),
    .spin_rev(spin_rev), .motor_current(motor_current), .trace_match(trace_match),
    .motor_reverse(motor_reverse));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one idle edge after release so the next setup never lands in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    if (pready === 1'b1 && exp_q.size() > 0)
    begin
      got = {pslverr, prdata};
      want = exp_q.pop_front();
      `CHK("apb answer", want, got)
    end
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    $display("MISMATCH watchdog exp done got hang");
    summarize();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_START, 32'h32);
    rd(OFS_STOP, 32'h32);
    rd(OFS_PRE, 32'h64);
    rd(OFS_POST, 32'h64);
    rd(OFS_BOOST, 32'h32);
    rd(OFS_SLIP, 32'h19);
    rd(OFS_RSPD, 32'h58c);
    apb(1'b0, 8'h3c, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h05, 32'h1, {1'b1, 32'h0});
    wr(OFS_START, 32'h7d0);
    rd(OFS_START, 32'h3e8);
    wr(OFS_START, 32'h32);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      v = seed[15:0];
      wr(OFS_POST, {16'h0, v});
      rd(OFS_POST, {16'h0, (v[15:8] > BRK_DUR_MAX) ? BRK_DUR_MAX : v[15:8],
                    (v[7:0] > BRK_LVL_MAX) ? BRK_LVL_MAX : v[7:0]});
    end
    // plain start behind two units of pre-start braking
    wr(OFS_RAMP, 32'h00010001);
    wr(OFS_PRE, 32'h0278);
    wr(OFS_CTRL, 32'h4);
    while (!dc_brake) @(posedge pclk);
    `CHK("pre level", 8'h78, brake_level)
    n = 0;
    while (dc_brake)
    begin
      n++;
      @(posedge pclk);
    end
    `CHK("pre time", 1'b1, n >= 16 && n <= 18)
    `CHK("no gap", 1'b1, gate_en)
    `CHK("start freq", 16'd51, out_freq)
    `CHK("boost", 1'b1, out_volt >= 11'd50)
    load_cur <= 16'd100;
    repeat (12) @(posedge pclk);
    `CHK("no trip at limit", 1'b0, trip)
    load_cur <= 16'd101;
    repeat (6) @(posedge pclk);
    `CHK("trip", 1'b1, trip)
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h10);
    repeat (3) @(posedge pclk);
    `CHK("trip clear", 1'b0, trip)
    // tracing start against a spinning reversed motor
    wr(OFS_RCUR, 32'h1f4);
    wr(OFS_PRE, 32'h64);
    spin_freq <= 16'd3000;
    spin_rev <= 1'b1;
    load_cur <= 16'd10;
    wr(OFS_CTRL, 32'h5);
    while (!gate_en) @(posedge pclk);
    `CHK("trace top", TOP_FREQ, out_freq)
    repeat (20) @(posedge pclk);
    `CHK("sweep down", 1'b1, out_freq < TOP_FREQ)
    load_cur <= 16'd200;
    repeat (4) @(posedge pclk);
    prev = out_freq;
    repeat (20) @(posedge pclk);
    `CHK("sweep paused", prev, out_freq)
    load_cur <= 16'd10;
    while (out_reverse !== 1'b1) @(posedge pclk);
    `CHK("caught speed", 1'b1, out_freq >= 16'd2990 && out_freq <= 16'd3100)
    // ramped stop ending in post-stop braking
    wr(OFS_POST, 32'h0150);
    wr(OFS_CTRL, 32'h1);
    repeat (8) @(posedge pclk);
    n = 0;
    repeat (40)
    begin
      prev = out_freq;
      @(posedge pclk);
      n += (out_freq < prev);
    end
    `CHK("decel rate", 1'b1, n >= 9 && n <= 11)
    while (!dc_brake) @(posedge pclk);
    `CHK("post level", 8'h50, brake_level)
    n = 0;
    while (dc_brake)
    begin
      n++;
      @(posedge pclk);
    end
    `CHK("post time", 1'b1, n >= 8 && n <= 10)
    `CHK("off after brake", 1'b0, gate_en)
    // coasting stop
    wr(OFS_CTRL, 32'h6);
    repeat (20) @(posedge pclk);
    `CHK("running", 1'b1, gate_en)
    // display lags out_freq by a cycle, so allow one unit either way
    n = int'(out_freq) * RSPD_DEF / 5000;
    `CHK("speed", 1'b1, speed_rpm + 16'd1 >= n && speed_rpm <= n + 1)
    wr(OFS_CTRL, 32'h2);
    repeat (3) @(posedge pclk);
    `CHK("coast gate", 1'b0, gate_en)
    `CHK("coast freq", 16'h0, out_freq)
    summarize();
  end
endmodule
`default_nettype wire
